// ==== chan_correct_ctrl.sv ====
// Channel offset, gain and phase control with serial register access
`timescale 1ns/1ps
`default_nettype none
module chan_correct_ctrl #(
  parameter logic [23:0] FACTORY_GAIN = chan_correct_pkg::UNITY_GAIN
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic format_select_low,
  input wire logic format_select_high,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic sync_in_n,
  input wire logic modulator_clock,
  input wire logic [2:0] general_pins_in,
  output logic [2:0] general_pins_out,
  output logic [2:0] general_pins_oe,
  input wire logic in_valid,
  input wire logic [2:0] in_chan,
  input wire logic [23:0] in_data,
  output logic out_valid,
  output logic [2:0] out_chan,
  output logic [23:0] out_data,
  output logic [7:0] filter_start,
  output logic [15:0] amplifier_gain,
  output logic low_power_mode,
  output logic [11:0] decimation_rate,
  output logic rate_strobe,
  output logic serial_mode
);
  localparam int P_CS = 0;
  localparam int P_SCLK = 1;
  localparam int P_SDI = 2;
  localparam int P_SYNC = 3;
  localparam int P_MOD = 4;
  localparam int P_FMT0 = 5;
  localparam int P_FMT1 = 6;
  localparam int P_GP = 7;

  typedef struct packed {
    logic [9:0] meta;
    logic [9:0] pins;
    logic [9:0] pins_d;
    logic [4:0] bit_cnt;
    logic [15:0] shift_in;
    logic [31:0] shift_out;
    logic [7:0][7:0] setup;
    logic [7:0][7:0] phase;
    logic [7:0][23:0] gain;
    logic [7:0][23:0] offset;
    logic [2:0] pin_dir;
    logic [2:0] pin_out;
    logic [11:0] dec_pend;
    logic [11:0] dec_act;
    logic [2:0] ctrl;
    logic [2:0] rd_chan;
    logic [7:0][23:0] last;
    logic [15:0] odr_cnt;
    logic odr;
    logic ov;
    logic [2:0] och;
    logic [23:0] od;
  } ctrl_state_t;

  ctrl_state_t r;
  ctrl_state_t next_r;
  logic [7:0][11:0] eff_delay;
  logic sync_event;
  logic mod_tick;

  // ==========================================================
  // Helpers
  function automatic logic [2:0] dec_shift(input logic [11:0] dec);
    if (dec <= chan_correct_pkg::RANGE_X1) begin
      return 3'd0;
    end else if (dec <= chan_correct_pkg::RANGE_X2) begin
      return 3'd1;
    end else if (dec <= chan_correct_pkg::RANGE_X4) begin
      return 3'd2;
    end else if (dec <= chan_correct_pkg::RANGE_X8) begin
      return 3'd3;
    end else begin
      return 3'd4;
    end
  endfunction : dec_shift

  function automatic logic [11:0] clip_delay(input logic [7:0] v, input logic [11:0] dec);
    logic [11:0] p;
    p = {4'h0, v} << dec_shift(dec);
    if (dec == '0) begin
      p = '0;
    end else if (p >= dec) begin
      p = dec - 1'b1;
    end
    return p;
  endfunction : clip_delay

  // Low bits of a large product are lost in the stored byte
  function automatic logic [7:0] fit_byte(input logic [11:0] p);
    logic [11:0] q;
    q = p >> dec_shift(p);
    return q[7:0];
  endfunction : fit_byte

  // Unmapped addresses read back as zero
  function automatic logic [7:0] reg_read(input ctrl_state_t s, input logic [6:0] a);
    logic [6:0] idx;
    logic [7:0] res;
    logic [23:0] w;
    idx = '0;
    res = '0;
    w = '0;
    if (a < chan_correct_pkg::ADDR_PHASE_BASE) begin
      res = s.setup[a[2:0]];
    end else if (a < chan_correct_pkg::ADDR_GAIN_BASE) begin
      res = s.phase[a[2:0]];
    end else if (a < chan_correct_pkg::ADDR_OFFSET_BASE) begin
      idx = a - chan_correct_pkg::ADDR_GAIN_BASE;
      w = s.gain[3'(idx / 7'd3)];
      res = w[8*(2-(idx % 7'd3)) +: 8];
    end else if (a < chan_correct_pkg::ADDR_PIN_DIR) begin
      idx = a - chan_correct_pkg::ADDR_OFFSET_BASE;
      w = s.offset[3'(idx / 7'd3)];
      res = w[8*(2-(idx % 7'd3)) +: 8];
    end else if (a == chan_correct_pkg::ADDR_PIN_DIR) begin
      res = {5'h00, s.pin_dir};
    end else if (a == chan_correct_pkg::ADDR_PIN_LEVELS) begin
      res = {5'h00, s.pins[P_GP +: 3]};
    end else if (a == chan_correct_pkg::ADDR_DEC_HIGH) begin
      res = {4'h0, s.dec_pend[11:8]};
    end else if (a == chan_correct_pkg::ADDR_DEC_LOW) begin
      res = s.dec_pend[7:0];
    end else if (a == chan_correct_pkg::ADDR_CONTROL) begin
      res = {5'h00, s.ctrl};
    end
    return res;
  endfunction : reg_read

  // ==========================================================
  // Main state update
  always_comb begin
    logic [15:0] word;
    logic [6:0] a;
    logic [6:0] idx;
    logic [2:0] ch;
    logic [4:0] k;
    logic mode;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic trig;
    logic [15:0] period;
    logic signed [26:0] pre;
    logic signed [51:0] prod;
    logic signed [27:0] scaled;
    logic [23:0] sat;
    word = '0;
    a = '0;
    idx = '0;
    ch = '0;
    k = '0;
    trig = 1'b0;
    period = '0;
    pre = '0;
    prod = '0;
    scaled = '0;
    sat = '0;
    mode = 1'b0;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    cs_fall = 1'b0;
    next_r = r;
    next_r.meta = {general_pins_in, format_select_high, format_select_low, modulator_clock,
                   sync_in_n, spi_sdi, spi_sclk, spi_cs_n};
    next_r.pins = r.meta;
    next_r.pins_d = r.pins;
    mode = r.pins[P_FMT0] & r.pins[P_FMT1];
    sclk_rise = r.pins[P_SCLK] & ~r.pins_d[P_SCLK];
    sclk_fall = ~r.pins[P_SCLK] & r.pins_d[P_SCLK];
    cs_fall = ~r.pins[P_CS] & r.pins_d[P_CS];
    next_r.ctrl[chan_correct_pkg::CTRL_RATE_UPDATE - 1] = r.ctrl[chan_correct_pkg::CTRL_RATE_UPDATE - 1];

    // ==========================================================
    // Serial frame: bit 15 read, bits 14:8 address, bits 7:0 data
    if (r.pins[P_CS] || !mode) begin
      next_r.bit_cnt = '0;
    end else begin
      if (cs_fall && r.ctrl[chan_correct_pkg::CTRL_READOUT]) begin
        next_r.shift_out = {5'h00, r.rd_chan, r.last[r.rd_chan]};
        next_r.rd_chan = r.rd_chan + 1'b1;
      end else if (cs_fall) begin
        next_r.shift_out = '0;
      end
      if (sclk_fall) begin
        next_r.shift_out = {r.shift_out[30:0], 1'b0};
      end
      if (sclk_rise) begin
        word = {r.shift_in[14:0], r.pins[P_SDI]};
        next_r.shift_in = word;
        next_r.bit_cnt = (r.bit_cnt == 5'(chan_correct_pkg::FRAME_BITS)) ? 5'd1 : r.bit_cnt + 1'b1;
        if (next_r.bit_cnt == 5'(chan_correct_pkg::ADDR_PHASE_END) && word[7] &&
            !r.ctrl[chan_correct_pkg::CTRL_READOUT]) begin
          next_r.shift_out = {1'b0, reg_read(r, word[6:0]), 23'h00_0000};
        end
        if (next_r.bit_cnt == 5'(chan_correct_pkg::FRAME_BITS) && !word[15]) begin
          a = word[14:8];
          if (a < chan_correct_pkg::ADDR_PHASE_BASE) begin
            next_r.setup[a[2:0]] = word[7:0];
          end else if (a < chan_correct_pkg::ADDR_GAIN_BASE) begin
            next_r.phase[a[2:0]] = fit_byte(clip_delay(word[7:0], r.dec_act));
          end else if (a < chan_correct_pkg::ADDR_OFFSET_BASE) begin
            idx = a - chan_correct_pkg::ADDR_GAIN_BASE;
            ch = 3'(idx / 7'd3);
            k = 5'(8 * (2 - (idx % 7'd3)));
            next_r.gain[ch][k +: 8] = word[7:0];
          end else if (a < chan_correct_pkg::ADDR_PIN_DIR) begin
            idx = a - chan_correct_pkg::ADDR_OFFSET_BASE;
            ch = 3'(idx / 7'd3);
            k = 5'(8 * (2 - (idx % 7'd3)));
            next_r.offset[ch][k +: 8] = word[7:0];
          end else if (a == chan_correct_pkg::ADDR_PIN_DIR) begin
            next_r.pin_dir = word[2:0];
          end else if (a == chan_correct_pkg::ADDR_PIN_LEVELS) begin
            next_r.pin_out = word[2:0];
          end else if (a == chan_correct_pkg::ADDR_DEC_HIGH) begin
            next_r.dec_pend[11:8] = word[3:0];
          end else if (a == chan_correct_pkg::ADDR_DEC_LOW) begin
            next_r.dec_pend[7:0] = word[7:0];
          end else if (a == chan_correct_pkg::ADDR_CONTROL) begin
            next_r.ctrl = word[2:0];
            trig = word[chan_correct_pkg::CTRL_RATE_UPDATE];
          end
        end
      end
    end

    // ==========================================================
    // New decimation from software or from general pin 0 edge
    if (mode && r.ctrl[chan_correct_pkg::CTRL_PIN_TRIGGER] && !r.pin_dir[0] &&
        r.pins[P_GP] && !r.pins_d[P_GP]) begin
      trig = 1'b1;
    end
    if (trig) begin
      next_r.dec_act = next_r.dec_pend;
      next_r.odr_cnt = '0;
    end

    // ==========================================================
    // Output sample strobe, period 4 or 8 times decimation
    period = r.ctrl[chan_correct_pkg::CTRL_LOW_POWER] ?
             ({4'h0, r.dec_act} << chan_correct_pkg::RATE_SHIFT_LOW_POWER) :
             ({4'h0, r.dec_act} << chan_correct_pkg::RATE_SHIFT_HIGH_RES);
    next_r.odr = 1'b0;
    if (!trig) begin
      if (r.odr_cnt + 1'b1 >= period) begin
        next_r.odr_cnt = '0;
        next_r.odr = (period != '0);
      end else begin
        next_r.odr_cnt = r.odr_cnt + 1'b1;
      end
    end

    // ==========================================================
    // Correction: (3x - 4*offset) * gain / 2^24, 0x555555 is unity
    pre = (27'($signed(in_data)) <<< 1) + 27'($signed(in_data))
          - (27'($signed(r.offset[in_chan])) <<< 2);
    prod = 52'(pre) * $signed({28'h000_0000, r.gain[in_chan]});
    scaled = prod[51:24];
    // Saturate instead of wrapping at full scale
    if (scaled > chan_correct_pkg::SAT_MAX) begin
      sat = 24'h7F_FFFF;
    end else if (scaled < chan_correct_pkg::SAT_MIN) begin
      sat = 24'h80_0000;
    end else begin
      sat = scaled[23:0];
    end
    next_r.ov = in_valid;
    if (in_valid) begin
      next_r.och = in_chan;
      next_r.od = sat;
      next_r.last[in_chan] = sat;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      // Select and sync idle high, so no false frame or sync edge
      r.meta <= '1;
      r.pins <= '1;
      r.pins_d <= '1;
      r.gain <= {chan_correct_pkg::NUM_CHAN{FACTORY_GAIN}};
      r.offset <= {chan_correct_pkg::NUM_CHAN{chan_correct_pkg::OFFSET_RESET}};
      r.dec_pend <= chan_correct_pkg::DEC_RESET;
      r.dec_act <= chan_correct_pkg::DEC_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Phase delay per channel
  // Edges come from the synced copies, never the raw pins
  assign sync_event = ~r.pins[P_SYNC] & r.pins_d[P_SYNC];
  assign mod_tick = r.pins[P_MOD] & ~r.pins_d[P_MOD];

  genvar gi;
  generate
    for (gi = 0; gi < chan_correct_pkg::NUM_CHAN; gi++) begin : g_chan
      assign eff_delay[gi] = clip_delay(r.phase[gi], r.dec_act);
      assign amplifier_gain[2*gi +: 2] = r.setup[gi][chan_correct_pkg::GAIN_SEL_HI:chan_correct_pkg::GAIN_SEL_LO];
      phase_start_delay #(
        .CNT_W(chan_correct_pkg::DEC_W)
      ) u_delay (
        .clk(clk),
        .rst(rst),
        .sync_event(sync_event),
        .mod_tick(mod_tick),
        .delay_in(eff_delay[gi]),
        .filter_start(filter_start[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Outputs
  assign serial_mode = r.pins[P_FMT0] & r.pins[P_FMT1];
  assign spi_sdo = r.shift_out[31];
  assign spi_sdo_oe = serial_mode & ~r.pins[P_CS];
  assign general_pins_out = r.pin_out;
  // Pins are released outside serial control
  assign general_pins_oe = serial_mode ? r.pin_dir : 3'b000;
  assign out_valid = r.ov;
  assign out_chan = r.och;
  assign out_data = r.od;
  assign low_power_mode = r.ctrl[chan_correct_pkg::CTRL_LOW_POWER];
  assign decimation_rate = r.dec_act;
  assign rate_strobe = r.odr;
endmodule : chan_correct_ctrl
`default_nettype wire

// ==== chan_correct_pkg.sv ====
// Constants shared by the channel correction and control block
`default_nettype none
package chan_correct_pkg;
  localparam int NUM_CHAN = 8;
  localparam int DATA_W = 24;
  localparam int DEC_W = 12;
  localparam int PIN_COUNT = 3;
  localparam int ADDR_W = 7;
  // ==========================================================
  // Register map
  localparam logic [6:0] ADDR_SETUP_BASE = 7'h00;
  localparam logic [6:0] ADDR_PHASE_BASE = 7'h08;
  localparam logic [6:0] ADDR_GAIN_BASE = 7'h10;
  localparam logic [6:0] ADDR_OFFSET_BASE = 7'h28;
  localparam logic [6:0] ADDR_PIN_DIR = 7'h40;
  localparam logic [6:0] ADDR_PIN_LEVELS = 7'h41;
  localparam logic [6:0] ADDR_DEC_HIGH = 7'h42;
  localparam logic [6:0] ADDR_DEC_LOW = 7'h43;
  localparam logic [6:0] ADDR_CONTROL = 7'h44;
  // ==========================================================
  // Field positions
  localparam int CTRL_LOW_POWER = 0;
  localparam int CTRL_READOUT = 1;
  localparam int CTRL_PIN_TRIGGER = 2;
  localparam int CTRL_RATE_UPDATE = 3;
  localparam int GAIN_SEL_HI = 7;
  localparam int GAIN_SEL_LO = 6;
  localparam int FRAME_BITS = 16;
  localparam int ADDR_PHASE_END = 8;
  // ==========================================================
  // Reset values
  localparam logic [23:0] UNITY_GAIN = 24'h55_5555;
  localparam logic [23:0] OFFSET_RESET = 24'h00_0000;
  localparam logic [11:0] DEC_RESET = 12'h020;
  // ==========================================================
  // Decimation ranges, rate multipliers and saturation limits
  localparam logic [11:0] RANGE_X1 = 12'h0FF;
  localparam logic [11:0] RANGE_X2 = 12'h1FF;
  localparam logic [11:0] RANGE_X4 = 12'h3FF;
  localparam logic [11:0] RANGE_X8 = 12'h7FF;
  localparam int RATE_SHIFT_HIGH_RES = 2;
  localparam int RATE_SHIFT_LOW_POWER = 3;
  localparam logic signed [27:0] SAT_MAX = 28'sh07F_FFFF;
  localparam logic signed [27:0] SAT_MIN = -28'sh080_0000;
endpackage : chan_correct_pkg
`default_nettype wire

// ==== phase_start_delay.sv ====
// Per-channel delay from sync event to digital filter start
`timescale 1ns/1ps
`default_nettype none
module phase_start_delay #(
  parameter int CNT_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sync_event,
  input wire logic mod_tick,
  input wire logic [CNT_W-1:0] delay_in,
  output logic filter_start
);
  typedef struct packed {
    logic busy;
    logic [CNT_W-1:0] count;
    logic start;
  } delay_state_t;

  delay_state_t r;
  delay_state_t next_r;

  // ==========================================================
  // Delay counter
  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    if (sync_event) begin
      // Delay captured here only, later writes wait for the next sync
      if (delay_in == '0) begin
        next_r.start = 1'b1;
        next_r.busy = 1'b0;
      end else begin
        next_r.busy = 1'b1;
        next_r.count = delay_in;
      end
    end else if (r.busy && mod_tick) begin
      next_r.count = r.count - 1'b1;
      if (r.count == CNT_W'(1)) begin
        next_r.start = 1'b1;
        next_r.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign filter_start = r.start;
endmodule : phase_start_delay
`default_nettype wire

// ==== spi_host_model.sv ====
// Serial host model that frames register and readout transfers
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clk,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_sdi,
  input wire logic spi_sdo
);
  // ==========
  // Mode 0 framing
  localparam int HALF = 10;
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
  end
  // Slow half period keeps the design's synchronisers well inside margin
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    rx = 32'h0000_0000;
    @(negedge clk);
    spi_cs_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      spi_sdi = tx[i];
      repeat (HALF) @(negedge clk);
      spi_sclk = 1'b1;
      rx[i] = spi_sdo;
      repeat (HALF) @(negedge clk);
      spi_sclk = 1'b0;
    end
    repeat (8) @(negedge clk);
    spi_cs_n = 1'b1;
    // Idle data line flips so a stale bit never reads as valid
    spi_sdi = ~spi_sdi;
    repeat (8) @(negedge clk);
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ==== chan_correct_assertions.sv ====
// Concurrent checks on the channel correction block ports
`timescale 1ns/1ps
`default_nettype none
module chan_correct_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic format_select_low,
  input wire logic format_select_high,
  input wire logic spi_cs_n,
  input wire logic spi_sdo_oe,
  input wire logic [2:0] general_pins_in,
  input wire logic [2:0] general_pins_oe,
  input wire logic in_valid,
  input wire logic [2:0] in_chan,
  input wire logic out_valid,
  input wire logic [2:0] out_chan,
  input wire logic [7:0] filter_start,
  input wire logic [11:0] decimation_rate,
  input wire logic rate_strobe,
  input wire logic serial_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========
  // Sample path
  chk_out_follows_in: assert property (in_valid |=> out_valid && out_chan == $past(in_chan))
    else $error("corrected sample missing or on wrong channel");
  chk_out_has_cause: assert property (out_valid |-> $past(in_valid))
    else $error("corrected sample without raw sample");
  // ==========
  // Mode and pins
  chk_mode_from_pins: assert property ((format_select_low && format_select_high)[*4] |-> serial_mode)
    else $error("serial mode not entered");
  chk_pins_idle_off: assert property ((!(format_select_low && format_select_high))[*4] |->
    !serial_mode && general_pins_oe == 3'h0)
    else $error("general pins driven outside serial mode");
  chk_sdo_quiet: assert property (spi_cs_n[*4] |-> !spi_sdo_oe)
    else $error("serial output driven while deselected");
  chk_dir_hold: assert property ((spi_cs_n && serial_mode)[*8] |-> $stable(general_pins_oe))
    else $error("pin direction changed without a frame");
  chk_rate_hold: assert property ((spi_cs_n && $stable(general_pins_in))[*6] |-> $stable(decimation_rate))
    else $error("decimation changed without a trigger");
  // ==========
  // Pulses
  chk_strobe_single: assert property (rate_strobe |=> !rate_strobe)
    else $error("rate strobe wider than one cycle");
  chk_start_single: assert property (filter_start != 8'h00 |=> (filter_start & $past(filter_start)) == 8'h00)
    else $error("filter start wider than one cycle");
endmodule : chan_correct_assertions
bind chan_correct_ctrl chan_correct_assertions chk (.clk, .rst, .format_select_low, .format_select_high, .spi_cs_n,
  .spi_sdo_oe, .general_pins_in, .general_pins_oe, .in_valid, .in_chan, .out_valid, .out_chan, .filter_start,
  .decimation_rate, .rate_strobe, .serial_mode);
`default_nettype wire

// ==== tb_chan_correct_ctrl.sv ====
// Self-checking bench for the channel correction block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %0h seen %0h", nm, (e), (g)); end end
module tb_chan_correct_ctrl;
  logic clk, rst, format_select_low, format_select_high, spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe;
  logic sync_in_n, modulator_clock, in_valid, out_valid, low_power_mode, rate_strobe, serial_mode, mod_run, sdo_line;
  logic [2:0] general_pins_in, general_pins_out, general_pins_oe, in_chan, out_chan;
  logic [23:0] in_data, out_data;
  logic [7:0] filter_start;
  logic [15:0] amplifier_gain;
  logic [11:0] decimation_rate;
  int err_total, n_checks, ticks;
  int st[8];
  chan_correct_ctrl dut (.clk, .rst, .format_select_low, .format_select_high, .spi_cs_n, .spi_sclk, .spi_sdi,
    .spi_sdo, .spi_sdo_oe, .sync_in_n, .modulator_clock, .general_pins_in, .general_pins_out, .general_pins_oe,
    .in_valid, .in_chan, .in_data, .out_valid, .out_chan, .out_data, .filter_start, .amplifier_gain,
    .low_power_mode, .decimation_rate, .rate_strobe, .serial_mode);
  // Released output shows the inverse of its last bit
  assign sdo_line = spi_sdo_oe ? spi_sdo : ~spi_sdo;
  spi_host_model host (.clk, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo(sdo_line));
  // ==========
  // Clocks and monitors
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    modulator_clock = 1'b0;
    forever begin
      repeat (4) @(negedge clk);
      if (mod_run) modulator_clock = ~modulator_clock;
    end
  end
  always @(posedge modulator_clock) ticks++;
  always @(posedge clk) for (int i = 0; i < 8; i++) if (filter_start[i] === 1'b1) st[i]++;
  // ==========
  // Helpers
  function automatic logic [23:0] exp_out(input logic signed [23:0] x, input logic signed [23:0] o,
    input logic [23:0] g);
    logic signed [63:0] p;
    p = (64'sh3 * x - 64'sh4 * o) * $signed({1'b0, g});
    p = p >>> 24;
    if (p > 64'sh7F_FFFF) p = 64'sh7F_FFFF;
    else if (p < -64'sh80_0000) p = -64'sh80_0000;
    return p[23:0];
  endfunction : exp_out
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [31:0] r;
    host.xfer({16'h0000, 1'b0, a, d}, 16, r);
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    logic [31:0] r;
    host.xfer({16'h0000, 1'b1, a, 8'h00}, 16, r);
    d = r[7:0];
  endtask : rd
  task automatic wr24(input logic [6:0] a, input logic [23:0] v);
    for (int k = 0; k < 3; k++) wr(a + 7'(k), v[23 - 8 * k -: 8]);
  endtask : wr24
  task automatic sample(input logic [2:0] c, input logic [23:0] x, input logic [23:0] e);
    @(negedge clk);
    in_valid = 1'b1;
    in_chan = c;
    in_data = x;
    @(negedge clk);
    in_valid = 1'b0;
    `CHK("out valid", 1'b1, out_valid)
    `CHK("out chan", c, out_chan)
    `CHK("out data", e, out_data)
  endtask : sample
  task automatic ph(input logic [7:0] v, input logic [7:0] e);
    logic [7:0] d;
    wr(chan_correct_pkg::ADDR_PHASE_BASE + 7'h01, v);
    rd(chan_correct_pkg::ADDR_PHASE_BASE + 7'h01, d);
    `CHK("phase stored", e, d)
  endtask : ph
  task automatic gap(output int n);
    for (int i = 0; i < 6000 && rate_strobe !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    for (n = 1; n < 6000 && rate_strobe !== 1'b1; n++) @(negedge clk);
  endtask : gap
  // ==========
  // Scenarios
  task automatic t_reset();
    logic [7:0] d;
    rd(chan_correct_pkg::ADDR_GAIN_BASE, d);
    `CHK("gain high", 8'h55, d)
    rd(chan_correct_pkg::ADDR_GAIN_BASE + 7'h17, d);
    `CHK("gain low", 8'h55, d)
    rd(chan_correct_pkg::ADDR_OFFSET_BASE + 7'h01, d);
    `CHK("offset mid", 8'h00, d)
    `CHK("serial mode", 1'b1, serial_mode)
    wr(7'h45, 8'hAA);
    rd(7'h45, d);
    `CHK("unmapped", 8'h00, d)
    $display("reset test done");
  endtask : t_reset
  task automatic t_readout();
    logic [31:0] r;
    logic [2:0] c0;
    wr(chan_correct_pkg::ADDR_CONTROL, 8'h02);
    for (int c = 0; c < 8; c++) sample(3'(c), 24'(c * 16 + 4), exp_out(24'(c * 16 + 4), 24'h00_0000,
      chan_correct_pkg::UNITY_GAIN));
    for (int k = 0; k < 2; k++) begin
      host.xfer(32'h0000_0000, 32, r);
      if (k == 1) `CHK("readout chan", c0 + 3'h1, r[26:24])
      c0 = r[26:24];
      `CHK("readout pad", 5'h00, r[31:27])
      `CHK("readout data", exp_out({17'h0_0000, c0, 4'h4}, 24'h00_0000, chan_correct_pkg::UNITY_GAIN), r[23:0])
    end
    wr(chan_correct_pkg::ADDR_CONTROL, 8'h00);
    $display("readout test done");
  endtask : t_readout
  task automatic t_path();
    wr24(chan_correct_pkg::ADDR_OFFSET_BASE + 7'h03, 24'hFF_FF70);
    wr24(chan_correct_pkg::ADDR_GAIN_BASE + 7'h03, 24'h40_0000);
    sample(3'h1, 24'h00_0064, exp_out(24'h00_0064, 24'hFF_FF70, 24'h40_0000));
    sample(3'h0, 24'h00_012C, exp_out(24'h00_012C, 24'h00_0000, chan_correct_pkg::UNITY_GAIN));
    wr24(chan_correct_pkg::ADDR_GAIN_BASE + 7'h06, 24'hFF_FFFF);
    sample(3'h2, 24'h7F_FFFF, 24'h7F_FFFF);
    $display("path test done");
  endtask : t_path
  task automatic t_amp();
    for (int k = 0; k < 4; k++) begin
      wr(chan_correct_pkg::ADDR_SETUP_BASE + 7'(k), 8'(k << 6));
      `CHK("amp gain", 2'(k), amplifier_gain[2 * k +: 2])
    end
    $display("amplifier test done");
  endtask : t_amp
  task automatic t_phase();
    ph(8'h0A, 8'h0A);
    ph(8'h28, 8'h1F);
    wr(chan_correct_pkg::ADDR_DEC_HIGH, 8'h01);
    wr(chan_correct_pkg::ADDR_DEC_LOW, 8'h2C);
    wr(chan_correct_pkg::ADDR_CONTROL, 8'h08);
    `CHK("dec update", 12'h12C, decimation_rate)
    ph(8'h64, 8'hC8);
    ph(8'hC8, 8'h95);
    wr(chan_correct_pkg::ADDR_DEC_HIGH, 8'h07);
    wr(chan_correct_pkg::ADDR_DEC_LOW, 8'hD0);
    wr(chan_correct_pkg::ADDR_CONTROL, 8'h08);
    `CHK("dec wide", 12'h7D0, decimation_rate)
    ph(8'h1F, 8'hF8);
    ph(8'hFA, 8'hF9);
    wr(chan_correct_pkg::ADDR_DEC_HIGH, 8'h01);
    wr(chan_correct_pkg::ADDR_DEC_LOW, 8'h2C);
    wr(chan_correct_pkg::ADDR_CONTROL, 8'h08);
    $display("phase test done");
  endtask : t_phase
  task automatic t_sync();
    wr(chan_correct_pkg::ADDR_PHASE_BASE, 8'h00);
    wr(chan_correct_pkg::ADDR_PHASE_BASE + 7'h03, 8'h05);
    st[0] = 0;
    st[3] = 0;
    sync_in_n = 1'b0;
    for (int i = 0; i < 14; i++) begin
      @(negedge clk);
      if (i == 4) sync_in_n = 1'b1;
    end
    `CHK("start zero", 1, st[0])
    `CHK("start early", 0, st[3])
    ticks = 0;
    mod_run = 1'b1;
    for (int i = 0; i < 400 && filter_start[3] !== 1'b1; i++) @(negedge clk);
    `CHK("start ticks", 20, ticks)
    wr(chan_correct_pkg::ADDR_PHASE_BASE + 7'h03, 8'h02);
    repeat (200) @(negedge clk);
    `CHK("start count", 1, st[3])
    mod_run = 1'b0;
    $display("sync test done");
  endtask : t_sync
  task automatic t_rate();
    int n;
    gap(n);
    `CHK("rate high res", 4 * 300, n)
    wr(chan_correct_pkg::ADDR_CONTROL, 8'h01);
    `CHK("low power", 1'b1, low_power_mode)
    gap(n);
    gap(n);
    `CHK("rate low power", 8 * 300, n)
    wr(chan_correct_pkg::ADDR_CONTROL, 8'h00);
    $display("rate test done");
  endtask : t_rate
  task automatic t_pins();
    logic [7:0] d;
    wr(chan_correct_pkg::ADDR_PIN_DIR, 8'h05);
    `CHK("pin dir", 3'h5, general_pins_oe)
    wr(chan_correct_pkg::ADDR_PIN_LEVELS, 8'h03);
    `CHK("pin out", 3'h3, general_pins_out)
    general_pins_in = 3'h6;
    rd(chan_correct_pkg::ADDR_PIN_LEVELS, d);
    `CHK("pin in", 8'h06, d)
    format_select_low = 1'b0;
    repeat (8) @(negedge clk);
    `CHK("pin mode", 3'h0, general_pins_oe)
    format_select_low = 1'b1;
    repeat (8) @(negedge clk);
    wr(chan_correct_pkg::ADDR_PIN_DIR, 8'h00);
    wr(chan_correct_pkg::ADDR_DEC_HIGH, 8'h00);
    wr(chan_correct_pkg::ADDR_DEC_LOW, 8'h40);
    wr(chan_correct_pkg::ADDR_CONTROL, 8'h04);
    `CHK("dec pending", 12'h12C, decimation_rate)
    general_pins_in = 3'h7;
    repeat (8) @(negedge clk);
    `CHK("dec trigger", 12'h040, decimation_rate)
    $display("pins test done");
  endtask : t_pins
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    format_select_low = 1'b1;
    format_select_high = 1'b1;
    sync_in_n = 1'b1;
    general_pins_in = 3'h0;
    in_valid = 1'b0;
    in_chan = 3'h0;
    in_data = 24'h00_0000;
    mod_run = 1'b0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    t_reset();
    t_readout();
    t_path();
    t_amp();
    t_phase();
    t_sync();
    t_rate();
    t_pins();
    complete_run();
  end
endmodule : tb_chan_correct_ctrl
`default_nettype wire
